// ==== serial_flash_spi_front_end.sv ====
// Serial front end of a small serial flash: command framing,
// single and two-line data, pause, and write protection.
// Assumes link pins are asynchronous and oversampled by clock_in.
`timescale 1ns/1ps
`include "serial_flash_map.svh"
module serial_flash_spi_front_end #(
    parameter int PUW_CYCLES = `PUW_TIME_US * 1000 / `CLK_PERIOD_NS,
    parameter int BUSY_CYCLES = `BUSY_TIME_US * 1000 / `CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // Link pins
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic pause_n_in,
    input wire logic write_guard_n_in,
    input wire logic line_a_in,
    output logic line_a_out,
    output logic line_a_oe_out,
    input wire logic line_b_in,
    output logic line_b_out,
    output logic line_b_oe_out,
    // Array side
    output serial_flash_pkg::byte_t cmd_code_out,
    output logic cmd_start_out,
    output serial_flash_pkg::addr_t addr_out,
    output serial_flash_pkg::byte_t rx_byte_out,
    output logic rx_valid_out,
    input wire serial_flash_pkg::byte_t tx_byte_in,
    output logic tx_req_out,
    output logic op_start_out,
    output serial_flash_pkg::byte_t status_out
);
    import serial_flash_pkg::*;
    localparam int PW = $clog2(PUW_CYCLES + 1);
    localparam int BW = $clog2(BUSY_CYCLES + 1);
    // ----------------------------------------
    // Decode functions
    // ----------------------------------------
    // Instructions that alter the array or status
    function automatic logic is_wr(input byte_t op);
        return op inside {`OP_WR_EN, `OP_WR_STAT, `OP_PROG, `OP_ERASE_4K,
            `OP_ERASE_32K, `OP_ERASE_64K, `OP_ERASE_ALL, `OP_ERASE_ALL2};
    endfunction
    // Instructions that shift data out
    function automatic logic is_tx(input byte_t op);
        return op inside {`OP_RD_STAT, `OP_READ, `OP_FAST, `OP_DUAL_OUT,
            `OP_DUAL_IO};
    endfunction
    function automatic logic is_dual(input byte_t op);
        return op == `OP_DUAL_OUT || op == `OP_DUAL_IO;
    endfunction
    // Clocks before the first output bit
    function automatic logic [5:0] pre_len(input byte_t op);
        case (op)
            `OP_RD_STAT: return `LEN_OPC;
            `OP_READ: return `PRE_READ;
            `OP_DUAL_IO: return `PRE_DUAL_IO;
            default: return `PRE_FAST;
        endcase
    endfunction
    // Gate applied when the opcode arrives
    function automatic logic accept_op(input byte_t op, input logic pd,
            input logic busy, input logic puw, input logic wpl, input logic lk);
        logic known;
        known = is_wr(op) || is_tx(op) || op inside {`OP_WR_DIS, `OP_SLEEP,
            `OP_WAKE};
        if (pd) begin
            return op == `OP_WAKE;
        end
        if (busy) begin
            return op == `OP_RD_STAT;
        end
        if (is_wr(op) && puw) begin
            return 1'b0;
        end
        if (is_wr(op) && op != `OP_WR_EN && !wpl) begin
            return 1'b0;
        end
        if (op == `OP_WR_STAT && lk) begin
            return 1'b0;
        end
        return known;
    endfunction
    // Completion legal at select rise
    function automatic logic len_ok(input byte_t op, input logic [5:0] n,
            input logic [2:0] bib);
        case (op)
            `OP_WR_EN, `OP_WR_DIS, `OP_SLEEP: return n == `LEN_OPC;
            `OP_ERASE_ALL, `OP_ERASE_ALL2: return n == `LEN_OPC;
            `OP_WR_STAT: return n == `LEN_STAT;
            `OP_ERASE_4K, `OP_ERASE_32K, `OP_ERASE_64K: return n == `LEN_ADDR;
            `OP_PROG: return n >= `LEN_PROG && bib == 3'h0;
            `OP_WAKE: return n >= `LEN_OPC;
            default: return 1'b0;
        endcase
    endfunction
    // Region guard lookup
    function automatic logic guarded(input addr_t a, input logic [1:0] rg,
            input logic dir);
        if (rg[1]) begin
            return 1'b1;
        end
        if (rg[0]) begin
            return dir ? ~a[`HALF_ADDR_BIT] : a[`HALF_ADDR_BIT];
        end
        return 1'b0;
    endfunction
    // ----------------------------------------
    // Pin synchronisers and edges
    // ----------------------------------------
    logic sclk_s, cs_n_s, pause_n_s, wg_n_s, a_s, b_s;
    logic sclk_d_r; // Previous serial clock
    logic cs_d_r; // Previous select
    logic paused; // Pause in force
    // Select resets low so held-low select gives no edge
    sync_2ff #(.W(6), .RST(6'h0F)) u_sync (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .async_in({sclk_in, cs_n_in, pause_n_in, write_guard_n_in,
            line_a_in, line_b_in}),
        .sync_out({sclk_s, cs_n_s, pause_n_s, wg_n_s, a_s, b_s})
    );
    spi_pause_ctrl u_pause (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .selected_in(~cs_n_s),
        .sclk_in(sclk_s),
        .pause_n_in(pause_n_s),
        .paused_out(paused)
    );
    // Edge history
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sclk_d_r <= 1'b0;
            cs_d_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk_s;
            cs_d_r <= cs_n_s;
        end
    end
    // ----------------------------------------
    // Frame state
    // ----------------------------------------
    frame_state_t st_r, st_nxt; // Frame state
    byte_t op_r; // Last received opcode, accepted or not
    logic [5:0] rcnt_r; // Rising edges, saturating
    logic [2:0] bib_r; // Bit within byte
    logic [31:0] in_sr_r, in_nxt; // Input shifter
    logic wpl_r, busy, pd_r, lock_r, dir_r; // Status state
    logic [1:0] rg_r; // Region guard
    logic [PW-1:0] puw_cnt_r; // Write lockout after reset
    logic [BW-1:0] busy_cnt_r; // Internal operation timer
    addr_t addr_r;
    logic cs_fall, cs_rise, run, run_rise, run_fall, opc_rise, dual_in;
    logic locked, accept, done, wr_done, guard_hit, st_commit, exec_start;
    assign cs_fall = ~cs_n_s & cs_d_r;
    assign cs_rise = cs_n_s & ~cs_d_r;
    assign run = (st_r == FR_OPC || st_r == FR_BODY) && !paused && !cs_n_s;
    assign run_rise = run & sclk_s & ~sclk_d_r;
    assign run_fall = run & ~sclk_s & sclk_d_r;
    assign opc_rise = run_rise && st_r == FR_OPC && rcnt_r == `LEN_OPC - 6'h01;
    assign dual_in = st_r == FR_BODY && op_r == `OP_DUAL_IO &&
        rcnt_r < `PRE_DUAL_IO;
    // Two bits per clock in the two-line address phase
    assign in_nxt = dual_in ? {in_sr_r[29:0], b_s, a_s} : {in_sr_r[30:0], a_s};
    assign locked = lock_r & ~wg_n_s;
    assign accept = accept_op(in_nxt[7:0], pd_r, busy, |puw_cnt_r, wpl_r,
        locked);
    assign done = cs_rise && st_r == FR_BODY && len_ok(op_r, rcnt_r, bib_r);
    assign wr_done = done && is_wr(op_r) && op_r != `OP_WR_EN;
    assign guard_hit = (op_r == `OP_ERASE_ALL || op_r == `OP_ERASE_ALL2) ?
        |rg_r : guarded(addr_r, rg_r, dir_r);
    assign st_commit = wr_done && op_r == `OP_WR_STAT && !locked;
    assign exec_start = wr_done && (op_r == `OP_WR_STAT ? !locked : !guard_hit);
    assign busy = |busy_cnt_r;
    // Next frame state; select high always returns to idle
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            FR_IDLE: begin
                if (cs_fall) begin
                    st_nxt = FR_OPC;
                end
            end
            FR_OPC: begin
                if (opc_rise) begin
                    st_nxt = accept ? FR_BODY : FR_DROP;
                end
            end
            FR_BODY, FR_DROP: st_nxt = st_r;
            default: st_nxt = FR_IDLE;
        endcase
        if (cs_n_s) begin
            st_nxt = FR_IDLE;
        end
    end
    // Frame state register; paused frames simply hold
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_r <= FR_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end
    // Edge counters
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rcnt_r <= 6'h00;
            bib_r <= 3'h0;
        end else if (cs_fall) begin
            rcnt_r <= 6'h00;
            bib_r <= 3'h0;
        end else if (run_rise) begin
            rcnt_r <= (rcnt_r == `CNT_MAX) ? rcnt_r : rcnt_r + 6'h01;
            bib_r <= bib_r + 3'h1;
        end
    end
    // Input shifter, opcode and address capture
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            in_sr_r <= 32'h0000_0000;
            op_r <= 8'h00;
            addr_r <= 24'h00_0000;
        end else if (run_rise) begin
            in_sr_r <= in_nxt;
            if (opc_rise) begin
                op_r <= in_nxt[7:0];
            end
            if (dual_in && rcnt_r == `PRE_DUAL_IO - 6'h01) begin
                addr_r <= in_nxt[31:8];
            end else if (op_r != `OP_DUAL_IO && rcnt_r == `LEN_ADDR - 6'h01) begin
                // Two-line address is taken in its own phase only
                addr_r <= in_nxt[23:0];
            end
        end
    end
    // ----------------------------------------
    // Array side strobes
    // ----------------------------------------
    logic rx_take;
    assign rx_take = run_rise && st_r == FR_BODY && !dual_in && bib_r == 3'h7;
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cmd_code_out <= 8'h00;
            cmd_start_out <= 1'b0;
            rx_byte_out <= 8'h00;
            rx_valid_out <= 1'b0;
            op_start_out <= 1'b0;
        end else begin
            cmd_start_out <= opc_rise & accept;
            rx_valid_out <= rx_take;
            op_start_out <= exec_start;
            if (opc_rise & accept) begin
                cmd_code_out <= in_nxt[7:0];
            end
            if (rx_take) begin
                rx_byte_out <= in_nxt[7:0];
            end
        end
    end
    assign addr_out = addr_r;
    // ----------------------------------------
    // Status register
    // ----------------------------------------
    // Reserved bits S6 and S4 fixed at zero
    assign status_out = {lock_r, 1'b0, dir_r, 1'b0, rg_r, wpl_r, busy};
    // Write permit latch
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wpl_r <= 1'(`STATUS_RST >> `ST_WPL);
        end else if (done && op_r == `OP_WR_EN) begin
            wpl_r <= 1'b1;
        end else if ((done && op_r == `OP_WR_DIS) || wr_done) begin
            wpl_r <= 1'b0;
        end
    end
    // Guard bits; held here from reset as factory default
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            lock_r <= 1'b0;
            dir_r <= 1'b0;
            rg_r <= 2'h0;
        end else if (st_commit) begin
            lock_r <= rx_byte_out[`ST_LOCK];
            dir_r <= rx_byte_out[`ST_DIR];
            rg_r <= rx_byte_out[`ST_RG_HI:`ST_RG_LO];
        end
    end
    // Sleep state
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pd_r <= 1'b0;
        end else if (done && op_r == `OP_SLEEP) begin
            pd_r <= 1'b1;
        end else if (done && op_r == `OP_WAKE) begin
            pd_r <= 1'b0;
        end
    end
    // Power-up lockout and busy timers
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            puw_cnt_r <= PW'(PUW_CYCLES);
            busy_cnt_r <= '0;
        end else begin
            if (|puw_cnt_r) begin
                puw_cnt_r <= puw_cnt_r - PW'(1);
            end
            if (exec_start) begin
                busy_cnt_r <= BW'(BUSY_CYCLES);
            end else if (busy) begin
                busy_cnt_r <= busy_cnt_r - BW'(1);
            end
        end
    end
    // ----------------------------------------
    // Output shifter
    // ----------------------------------------
    byte_t out_sr_r, tx_src;
    logic [2:0] ocnt_r; // Clocks left in byte
    logic tx_on_r, tx_fall, tx_load, dual_out;
    assign dual_out = is_dual(op_r);
    assign tx_fall = run_fall && st_r == FR_BODY && is_tx(op_r) &&
        rcnt_r >= pre_len(op_r);
    assign tx_load = tx_fall && ocnt_r == 3'h0;
    assign tx_src = (op_r == `OP_RD_STAT) ? status_out : tx_byte_in;
    // Shift on falling serial clock
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            out_sr_r <= 8'h00;
            ocnt_r <= 3'h0;
            line_a_out <= 1'b0;
            line_b_out <= 1'b0;
        end else if (cs_fall) begin
            ocnt_r <= 3'h0;
        end else if (tx_load) begin
            out_sr_r <= dual_out ? {tx_src[5:0], 2'h0} : {tx_src[6:0], 1'h0};
            ocnt_r <= dual_out ? 3'h3 : 3'h7;
            line_b_out <= tx_src[7];
            line_a_out <= tx_src[6];
        end else if (tx_fall) begin
            out_sr_r <= dual_out ? {out_sr_r[5:0], 2'h0} : {out_sr_r[6:0], 1'h0};
            ocnt_r <= ocnt_r - 3'h1;
            line_b_out <= out_sr_r[7];
            line_a_out <= out_sr_r[6];
        end
    end
    // Output phase flag and byte request
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tx_on_r <= 1'b0;
            tx_req_out <= 1'b0;
        end else begin
            tx_req_out <= tx_load && op_r != `OP_RD_STAT;
            if (cs_fall) begin
                tx_on_r <= 1'b0;
            end else if (tx_fall) begin
                tx_on_r <= 1'b1;
            end
        end
    end
    // Enables; released when deselected or paused
    assign line_b_oe_out = tx_on_r && st_r == FR_BODY && !paused && !cs_n_s;
    assign line_a_oe_out = line_b_oe_out && dual_out;
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_we_end;
        done && op_r == `OP_WR_EN;
    endsequence
    sequence s_wr_end;
        (done && op_r == `OP_WR_DIS) || wr_done;
    endsequence
    sequence s_body_entry;
        $rose(st_r == FR_BODY);
    endsequence
    property p_idle_quiet;
        cs_n_s |-> !line_a_oe_out && !line_b_oe_out;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("lines driven while deselected");
    property p_pause_quiet;
        paused |-> !line_a_oe_out && !line_b_oe_out;
    endproperty
    a_pause_quiet: assert property (p_pause_quiet) else $error("lines driven while paused");
    property p_lockout;
        |puw_cnt_r |-> !wpl_r && !busy;
    endproperty
    a_lockout: assert property (p_lockout) else $error("write state during lockout");
    property p_wpl_set;
        s_we_end |=> wpl_r;
    endproperty
    a_wpl_set: assert property (p_wpl_set) else $error("permit latch not set");
    property p_wpl_clear;
        s_wr_end |=> !wpl_r;
    endproperty
    a_wpl_clear: assert property (p_wpl_clear) else $error("permit latch not cleared");
    property p_need_wpl;
        s_body_entry ##0 (is_wr(op_r) && op_r != `OP_WR_EN) |-> $past(wpl_r);
    endproperty
    a_need_wpl: assert property (p_need_wpl) else $error("write taken without permit");
    property p_busy_gate;
        s_body_entry ##0 $past(busy) |-> op_r == `OP_RD_STAT;
    endproperty
    a_busy_gate: assert property (p_busy_gate) else $error("instruction taken while busy");
    property p_busy_run;
        exec_start |=> busy [*8] ##0 status_out[`ST_BUSY];
    endproperty
    a_busy_run: assert property (p_busy_run) else $error("busy flag dropped early");
    property p_sleep_gate;
        s_body_entry ##0 $past(pd_r) |-> op_r == `OP_WAKE;
    endproperty
    a_sleep_gate: assert property (p_sleep_gate) else $error("instruction taken asleep");
    property p_lock_guard;
        ($changed(rg_r) || $changed(dir_r)) |-> $past(!lock_r || wg_n_s);
    endproperty
    a_lock_guard: assert property (p_lock_guard) else $error("guard bits written while locked");
endmodule

// ==== serial_flash_map.svh ====
// Constants for the serial flash front end: opcodes, status bits, timing.
// Assumes inclusion by bare name from the front-end design module.
`ifndef SERIAL_FLASH_MAP_SVH
`define SERIAL_FLASH_MAP_SVH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define OP_WR_EN 8'h06
`define OP_WR_DIS 8'h04
`define OP_RD_STAT 8'h05
`define OP_WR_STAT 8'h01
`define OP_READ 8'h03
`define OP_FAST 8'h0B
`define OP_DUAL_OUT 8'h3B
`define OP_DUAL_IO 8'hBB
`define OP_PROG 8'h02
`define OP_ERASE_4K 8'h20
`define OP_ERASE_32K 8'h52
`define OP_ERASE_64K 8'hD8
`define OP_ERASE_ALL 8'hC7
`define OP_ERASE_ALL2 8'h60
`define OP_SLEEP 8'hB9
`define OP_WAKE 8'hAB
// ----------------------------------------
// Status bit positions and reset value
// ----------------------------------------
`define ST_BUSY 0
`define ST_WPL 1
`define ST_RG_LO 2
`define ST_RG_HI 3
`define ST_DIR 5
`define ST_LOCK 7
`define STATUS_RST 8'h00
// Address bit that splits the array in halves
`define HALF_ADDR_BIT 16
// ----------------------------------------
// Frame lengths in serial clocks
// ----------------------------------------
`define LEN_OPC 6'h08
`define LEN_STAT 6'h10
`define LEN_ADDR 6'h20
`define LEN_PROG 6'h28
`define PRE_READ 6'h20
`define PRE_FAST 6'h28
`define PRE_DUAL_IO 6'h18
`define CNT_MAX 6'h3F
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define PUW_TIME_US 10
`define BUSY_TIME_US 50
`endif

// ==== serial_flash_pkg.sv ====
// Types shared by the serial flash front end.
// Assumes the constants header is on the include path.
package serial_flash_pkg;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    // Frame state, Gray coded along idle-opcode-body
    typedef enum logic [1:0] {
        FR_IDLE = 2'b00,
        FR_OPC = 2'b01,
        FR_BODY = 2'b11,
        FR_DROP = 2'b10
    } frame_state_t;
    typedef logic [7:0] byte_t;
    typedef logic [23:0] addr_t;
endpackage

// ==== sync_2ff.sv ====
// Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes each bit is an independent level; reset value is a constant.
`timescale 1ns/1ps
module sync_2ff #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // Levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    // ----------------------------------------
    // Stages
    // ----------------------------------------
    logic [W-1:0] meta_r; // First stage, read only by the second
    // Two flops in series
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            meta_r <= RST;
            sync_out <= RST;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// ==== spi_pause_ctrl.sv ====
// Pause tracker for the serial front end.
// Assumes synchronised select, serial clock and pause levels.
`timescale 1ns/1ps
module spi_pause_ctrl (
    // Clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // Synchronised link levels
    input wire logic selected_in,
    input wire logic sclk_in,
    input wire logic pause_n_in,
    // Pause state
    output logic paused_out
);
    // ----------------------------------------
    // Pause state
    // ----------------------------------------
    // Follows pause only while the serial clock is low and selected, clears when deselected;
    // with the clock high it waits for the next falling edge
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            paused_out <= 1'b0;
        end else if (!selected_in) begin
            paused_out <= 1'b0;
        end else if (!sclk_in) begin
            paused_out <= ~pause_n_in;
        end
    end
endmodule

// ==== spi_host_model.sv ====
// Host model: serial clock, select, pause and data line a.
// Assumes the bench resolves line b and passes it in.
`timescale 1ns/1ps
module spi_host_model (
    // Link pins
    output logic sclk_out,
    output logic cs_n_out,
    output logic pause_n_out,
    output logic line_a_out,
    input wire logic line_b_in,
    // Status read result
    output serial_flash_pkg::byte_t rd_out,
    output logic rd_valid_out
);
    import serial_flash_pkg::*;
    initial begin
        {sclk_out, cs_n_out, pause_n_out, line_a_out, rd_valid_out} = 5'h0E;
        rd_out = 8'h00;
    end
    // One frame, MSB first, optional pause at bit p
    task automatic frame(input logic [15:0] bits, input int n, input logic mode, input int p);
        sclk_out = mode;
        #62.5 cs_n_out = 1'b0;
        for (int i = 0; i < n; i++) begin
            #62.5 sclk_out = 1'b0;
            line_a_out = bits[15-i];
            if (i == p) begin
                pause_n_out = 1'b0;
                // Clock and data wiggle while paused; both must be ignored
                repeat (4) begin
                    #62.5 sclk_out = ~sclk_out;
                    line_a_out = ~line_a_out;
                end
                #62.5 pause_n_out = 1'b1;
            end
            #62.5 sclk_out = 1'b1;
            rd_out = {rd_out[6:0], line_b_in};
        end
        #62.5 sclk_out = mode;
        #62.5 cs_n_out = 1'b1;
        // Released line shows no stale value
        line_a_out = ~line_a_out;
        rd_valid_out = (bits[15:8] == 8'h05);
        #10 rd_valid_out = 1'b0;
    endtask
endmodule

// ==== serial_flash_spi_front_end_bench.sv ====
// Bench: status reads, write permit, lockout, lock pin, pause.
// Assumes the host model and design files are compiled first.
`timescale 1ns/1ps
module serial_flash_spi_front_end_bench;
    import serial_flash_pkg::*;
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic guard_n = 1'b1;
    logic b_float = 1'b0;
    logic [31:0] seed = 32'h5E;
    byte_t tx_byte = 8'h00;
    byte_t exp_q[$];
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    int starts = 0; // Internal operations started
    wire sclk, cs_n, pause_n, line_a, a_dev, a_oe, b_dev, b_oe, rd_valid, op_start;
    wire a_wire = a_oe ? a_dev : line_a;
    wire b_wire = b_oe ? b_dev : b_float;
    wire byte_t rd;
    wire byte_t stat;
    spi_host_model h (.sclk_out(sclk), .cs_n_out(cs_n), .pause_n_out(pause_n),
        .line_a_out(line_a), .line_b_in(b_wire), .rd_out(rd), .rd_valid_out(rd_valid));
    serial_flash_spi_front_end #(.PUW_CYCLES(200), .BUSY_CYCLES(400)) dut (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .sclk_in(sclk), .cs_n_in(cs_n),
        .pause_n_in(pause_n), .write_guard_n_in(guard_n), .line_a_in(a_wire),
        .line_a_out(a_dev), .line_a_oe_out(a_oe), .line_b_in(b_wire), .line_b_out(b_dev),
        .line_b_oe_out(b_oe), .cmd_code_out(), .cmd_start_out(), .addr_out(),
        .rx_byte_out(), .rx_valid_out(), .tx_byte_in(tx_byte), .tx_req_out(),
        .op_start_out(op_start), .status_out(stat));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic check(input byte_t exp, input byte_t got);
        comparisons++;
        if (exp !== got) begin
            mismatches++;
            $display("[FAIL] %0t exp %h got %h", $time, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Random mode per frame; starts off the clock edge
    task automatic op(input logic [15:0] bits, input int n, input int p);
        @(posedge clock_in);
        #3;
        h.frame(bits, n, seed[8], p);
    endtask
    // Status read, then line b must be released
    task automatic rd_stat(input byte_t exp);
        exp_q.push_back(exp);
        op(16'h0500, 16, -1);
        repeat (4) @(negedge clock_in);
        check(8'h00, {7'h00, b_oe});
        check(exp, stat);
        $display("status read %h done", exp);
    endtask
    always #5 clock_in = ~clock_in;
    // Random read data, floating line pattern, timeout
    always @(posedge clock_in) begin
        seed = xs(seed);
        tx_byte <= seed[7:0];
        b_float <= ~b_float;
        cycles <= cycles + 1;
        if (op_start) begin
            starts <= starts + 1;
        end
        if (cycles == 10000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    // Oldest note against each status byte read
    always @(posedge rd_valid) check(exp_q.pop_front(), rd);
    initial begin
        repeat (12) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        op(16'h0600, 8, -1);
        rd_stat(8'h00);
        op(16'h0600, 8, 3);
        rd_stat(8'h02);
        op(16'h0400, 8, -1);
        rd_stat(8'h00);
        op(16'h01FC, 16, -1);
        rd_stat(8'h00);
        op(16'h0600, 8, -1);
        op(16'h01FC, 16, -1);
        rd_stat(8'hAD);
        op(16'h0600, 8, -1);
        repeat (100) @(posedge clock_in);
        rd_stat(8'hAC);
        op(16'h0600, 8, -1);
        op(16'hC700, 8, -1);
        rd_stat(8'hAC);
        @(posedge clock_in) guard_n <= 1'b0;
        op(16'h0600, 8, -1);
        op(16'h0100, 16, -1);
        rd_stat(8'hAE);
        @(posedge clock_in) guard_n <= 1'b1;
        op(16'h0100, 16, -1);
        repeat (420) @(posedge clock_in);
        rd_stat(8'h00);
        op(16'hB900, 8, -1);
        op(16'h0600, 8, -1);
        op(16'hAB00, 8, -1);
        rd_stat(8'h00);
        check(8'h02, starts[7:0]);
        tally_and_finish();
    end
endmodule
